// ==== design/rcp_consts.svh ====
/*
  Timing counts, field positions and reset values for the reset, clock and
  power-save control block. Assumes a 100 MHz system clock.
*/
`ifndef RCP_CONSTS_SVH
`define RCP_CONSTS_SVH

`define CLK_PERIOD_NS        10
`define POR_HOLD_NS          1000000
`define POR_HOLD_CYC         (`POR_HOLD_NS / `CLK_PERIOD_NS)
`define INIT_INTERVAL_CYC    16
`define BOOT_ADDR            20'hFFFF0
`define BOOT_WAIT_STATES     2'h3
`define CLKEN_A_BIT          8
`define CLKEN_B_BIT          9
`define CLKFULL_A_BIT        10
`define CLKFULL_B_BIT        11
`define PSAVE_EN_BIT         15
`define PSAVE_DIV_LSB        0
`define PSAVE_DIV_W          3
`define PSC_RESET            16'h0300
`define BUS_T3               2'h2
`define DIV_W                8

`endif

// ==== design/rcp_pkg.sv ====
/*
  Types shared by the reset, clock and power-save control block.
  Assumes rcp_consts.svh is reachable on the include path.
*/
package rcp_pkg;

  typedef enum logic [1:0]
  {
    ST_RESET = 2'b00,
    ST_INIT  = 2'b01,
    ST_RUN   = 2'b10,
    ST_FLOAT = 2'b11
  } seq_state_t;

endpackage : rcp_pkg

// ==== design/clk_div_if.sv ====
/*
  Carries the power-save divider setting and its enable pulse between the
  sequencer and the divider. Assumes one clock domain.
*/
`timescale 1ns/1ns
interface clk_div_if;
  logic [7:0] ratio;
  logic       active;
  logic       tick;
  modport ctrl (output ratio, output active, input tick);
  modport div  (input ratio, input active, output tick);
endinterface : clk_div_if

// ==== design/clk_div.sv ====
/*
  Power-save clock divider: produces a one-cycle enable every ratio plus one cycles.
  Assumes the same clock and synchronous reset as the parent.
*/
`timescale 1ns/1ns
`include "rcp_consts.svh"
module clk_div
  import rcp_pkg::*;
(
  input  wire logic clock,
  input  wire logic resetn,
  clk_div_if.div    dif
);

  typedef struct packed
  {
    logic [`DIV_W-1:0] cnt;
    logic              tick;
  } div_state_t;

  div_state_t st_r;
  div_state_t st_nxt;

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (!dif.active)
    begin
      st_nxt.cnt  = '0;
      st_nxt.tick = 1'b1;
    end
    else if (st_r.cnt >= dif.ratio)
    begin
      st_nxt.cnt  = '0;
      st_nxt.tick = 1'b1;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign dif.tick = st_r.tick;

endmodule : clk_div

// ==== design/reset_clock_power_control.sv ====
/*
  Reset sequencing, reset configuration latch, power-save clock slowing and
  clock output gating. Assumes reset_pin_n and the straps come from pins,
  the power-save control word is written by logic on the same clock, and
  the bus state code comes from the bus unit on the same clock.
*/
`timescale 1ns/1ns
`include "rcp_consts.svh"

// Functional notes
// - Bits 11 to 8 of power_save_control enable each clock output and pick its rate.
// - One clock output may run at full rate while the other runs at power-save rate.
// - In power-save mode core and peripherals get the slower clock enable.
// - An interrupt in power-save leaves it at the next internal edge in bus state three.
// - Power-on reset returns the PLL to its reset state.
// - Reset stops execution and bus activity and outranks every interrupt.
// - After reset and an internal interval, fetch starts at FFFF0h with upper select and 3 waits.
// - Reset loads preset register values and resets the watchdog.
// - While reset is low the bus value is captured continuously into the configuration register.
// - At reset release the last captured value is frozen and stays readable.
// - Bus drivers stay off for the whole of reset.
// - A low halving strap at the first reset release after power-on disables the PLL and runs from input clock over two.
// - Both emulation straps low at reset release float all pins until the next reset.
module reset_clock_power_control
  import rcp_pkg::*;
#(
  parameter int INIT_CYC = `INIT_INTERVAL_CYC
)
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        power_on,
  input  wire logic        reset_pin_n,
  input  wire logic [15:0] addr_data_bus,
  input  wire logic        clock_halving_strap_n,
  input  wire logic        emulation_strap_low_n,
  input  wire logic        emulation_strap_high_n,
  input  wire logic [15:0] power_save_control,
  input  wire logic        psc_write,
  input  wire logic        irq,
  input  wire logic [1:0]  bus_state,
  output logic [15:0]      reset_config,
  output logic [15:0]      psc_readback,
  output logic             core_reset,
  output logic             watchdog_reset,
  output logic             pll_reset,
  output logic             pll_bypass,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             clkout_a_en,
  output logic             clkout_b_en,
  output logic             bus_drive_en,
  output logic             pins_float,
  output logic             fetch_start,
  output logic [19:0]      fetch_addr,
  output logic             upper_select_n,
  output logic [1:0]       fetch_waits,
  output logic             psave_active
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed
  {
    logic [1:0]  rst_sync;
    logic [1:0]  str_c0;
    logic [1:0]  str_c1;
    logic [1:0]  str_e0;
    logic [1:0]  str_e1;
    logic [15:0] bus_s0;
    logic [15:0] bus_s1;
    seq_state_t  seq;
    logic [15:0] init_cnt;
    logic        pwr_first;
    logic [15:0] cfg;
    logic [15:0] psc;
    logic        psave;
    logic        exit_pend;
    logic        halve;
    logic        halve_ph;
    logic        core_rst;
    logic        wd_rst;
    logic        pll_rst;
    logic        pll_byp;
    logic        cpu_en;
    logic        per_en;
    logic        ca_en;
    logic        cb_en;
    logic        drive;
    logic        flt;
    logic        fetch;
    logic        usel_n;
  } ctl_state_t;

  ctl_state_t st_r;
  ctl_state_t st_nxt;

  clk_div_if dif ();

  clk_div u_div
  (
    .clock  (clock),
    .resetn (resetn),
    .dif    (dif)
  );

  assign dif.ratio  = {5'h00, st_r.psc[`PSAVE_DIV_LSB +: `PSAVE_DIV_W]};
  assign dif.active = st_r.psave;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  logic rst_low;
  logic rel_edge;
  logic base_tick;
  logic slow_tick;

  always_comb
  begin
    st_nxt          = st_r;
    // Pins pass two flops before anything reads them
    st_nxt.rst_sync = {st_r.rst_sync[0], reset_pin_n};
    st_nxt.str_c0   = {st_r.str_c0[0], clock_halving_strap_n};
    st_nxt.str_e0   = {st_r.str_e0[0], emulation_strap_low_n};
    st_nxt.str_e1   = {st_r.str_e1[0], emulation_strap_high_n};
    st_nxt.bus_s0   = addr_data_bus;
    st_nxt.bus_s1   = st_r.bus_s0;
    st_nxt.str_c1   = st_r.str_c1;
    rst_low         = !st_r.rst_sync[1];
    rel_edge        = (st_r.seq == ST_RESET) && !rst_low;
    st_nxt.fetch    = 1'b0;
    st_nxt.pll_rst  = 1'b0;
    st_nxt.halve_ph = st_r.halve ? !st_r.halve_ph : 1'b1;
    // Halving mode gives every other cycle; power-save divides further
    base_tick       = st_r.halve ? st_r.halve_ph : 1'b1;
    slow_tick       = base_tick && dif.tick;

    if (rst_low)
    begin
      st_nxt.seq       = ST_RESET;
      st_nxt.cfg       = st_r.bus_s1;
      st_nxt.drive     = 1'b0;
      st_nxt.flt       = 1'b0;
      st_nxt.core_rst  = 1'b1;
      st_nxt.wd_rst    = 1'b1;
      st_nxt.psc       = `PSC_RESET;
      st_nxt.psave     = 1'b0;
      st_nxt.exit_pend = 1'b0;
      st_nxt.pll_rst   = st_r.pwr_first;
      st_nxt.init_cnt  = '0;
    end
    else
    begin
      unique case (st_r.seq)
        ST_RESET:
        begin
          // Straps taken on the release edge; cfg keeps its last capture
          // Halving is decided only at power-on; warm resets keep it
          if (st_r.pwr_first)
          begin
            st_nxt.halve   = !st_r.str_c0[1];
            st_nxt.pll_byp = !st_r.str_c0[1];
          end
          st_nxt.pwr_first = 1'b0;
          if (!st_r.str_e0[1] && !st_r.str_e1[1])
            st_nxt.seq = ST_FLOAT;
          else
            st_nxt.seq = ST_INIT;
        end
        ST_INIT:
        begin
          st_nxt.wd_rst   = 1'b0;
          st_nxt.init_cnt = st_r.init_cnt + 16'h0001;
          if (st_r.init_cnt >= 16'(INIT_CYC - 1))
          begin
            st_nxt.seq      = ST_RUN;
            st_nxt.core_rst = 1'b0;
            st_nxt.drive    = 1'b1;
            st_nxt.fetch    = 1'b1;
          end
        end
        ST_RUN:
        begin
          if (psc_write)
          begin
            st_nxt.psc   = power_save_control;
            st_nxt.psave = power_save_control[`PSAVE_EN_BIT];
          end
          if (st_r.psave && (irq || st_r.exit_pend))
          begin
            // Leave only on an internal edge that lands in bus state three
            if (bus_state == `BUS_T3)
            begin
              st_nxt.psave     = 1'b0;
              st_nxt.exit_pend = 1'b0;
              st_nxt.psc[`PSAVE_EN_BIT] = 1'b0;
            end
            else
              st_nxt.exit_pend = 1'b1;
          end
        end
        ST_FLOAT:
        begin
          st_nxt.flt      = 1'b1;
          st_nxt.drive    = 1'b0;
          st_nxt.wd_rst   = 1'b0;
        end
      endcase
    end

    st_nxt.usel_n = !st_nxt.fetch;
    // Core and peripherals share the slowed enable in power-save
    st_nxt.cpu_en = !st_nxt.core_rst && (st_r.psave ? slow_tick : base_tick);
    st_nxt.per_en = st_r.psave ? slow_tick : base_tick;
    // Each output has its own enable and its own rate choice
    st_nxt.ca_en = !st_nxt.flt && st_r.psc[`CLKEN_A_BIT]
                   && ((st_r.psc[`CLKFULL_A_BIT] || !st_r.psave) ? base_tick : slow_tick);
    st_nxt.cb_en = !st_nxt.flt && st_r.psc[`CLKEN_B_BIT]
                   && ((st_r.psc[`CLKFULL_B_BIT] || !st_r.psave) ? base_tick : slow_tick);
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      st_r           <= '0;
      st_r.seq       <= ST_RESET;
      st_r.pwr_first <= 1'b1;
      st_r.core_rst  <= 1'b1;
      st_r.wd_rst    <= 1'b1;
      st_r.pll_rst   <= 1'b1;
      st_r.psc       <= `PSC_RESET;
      st_r.halve_ph  <= 1'b1;
      st_r.usel_n    <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // Power-on reset itself also clears the PLL; resetn stands for it here
  logic unused_power_on;
  assign unused_power_on = power_on;

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign reset_config   = st_r.cfg;
  assign psc_readback   = st_r.psc;
  assign core_reset     = st_r.core_rst;
  assign watchdog_reset = st_r.wd_rst;
  assign pll_reset      = st_r.pll_rst;
  assign pll_bypass     = st_r.pll_byp;
  assign cpu_clk_en     = st_r.cpu_en;
  assign periph_clk_en  = st_r.per_en;
  assign clkout_a_en    = st_r.ca_en;
  assign clkout_b_en    = st_r.cb_en;
  assign bus_drive_en   = st_r.drive;
  assign pins_float     = st_r.flt;
  assign fetch_start    = st_r.fetch;
  assign fetch_addr     = `BOOT_ADDR;
  assign upper_select_n = st_r.usel_n;
  assign fetch_waits    = `BOOT_WAIT_STATES;
  assign psave_active   = st_r.psave;

endmodule : reset_clock_power_control

// ==== testbench/strap_board.sv ====
/*
  Board model: drives the configuration word on the address/data bus while
  reset is low. Assumes the bus has no pull resistors once released.
*/
`timescale 1ns/1ns
module strap_board
(
  input  wire logic        clock,
  input  wire logic        reset_pin_n,
  input  wire logic [15:0] cfg_value,
  output logic [15:0]      addr_data_bus
);
  logic [2:0] hold_r = 3'h0;
  initial addr_data_bus = 16'h0000;
  always @(posedge clock)
  begin
    if (!reset_pin_n)
      hold_r <= 3'h6;
    else if (hold_r != 3'h0)
      hold_r <= hold_r - 3'h1;
    // Held a few cycles past release to cover the input synchroniser
    if (!reset_pin_n || hold_r != 3'h0)
      addr_data_bus <= cfg_value;
    else
      addr_data_bus <= ~addr_data_bus; // Released: flips so stale samples show
  end
endmodule : strap_board

// ==== testbench/rcp_props.sv ====
/*
  Port checker for reset_clock_power_control.
  Assumes bus_state 2'h2 marks the third bus state.
*/
`timescale 1ns/1ns
module rcp_props
(
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        reset_pin_n,
  input wire logic [15:0] addr_data_bus,
  input wire logic [15:0] power_save_control,
  input wire logic        psc_write,
  input wire logic        irq,
  input wire logic [1:0]  bus_state,
  input wire logic [15:0] reset_config,
  input wire logic [15:0] psc_readback,
  input wire logic        core_reset,
  input wire logic        watchdog_reset,
  input wire logic        pll_bypass,
  input wire logic        cpu_clk_en,
  input wire logic        clkout_b_en,
  input wire logic        bus_drive_en,
  input wire logic        pins_float,
  input wire logic        fetch_start,
  input wire logic [19:0] fetch_addr,
  input wire logic        upper_select_n,
  input wire logic [1:0]  fetch_waits,
  input wire logic        psave_active
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_boot;
    fetch_start |-> fetch_addr == 20'hFFFF0 && fetch_waits == 2'h3 && !upper_select_n;
  endproperty
  a_boot: assert property (p_boot) else $error("boot fetch wrong");
  property p_stop;
    (!reset_pin_n)[*4] |-> core_reset && watchdog_reset;
  endproperty
  a_stop: assert property (p_stop) else $error("reset not applied");
  property p_tri;
    core_reset || pins_float |-> !bus_drive_en && !fetch_start;
  endproperty
  a_tri: assert property (p_tri) else $error("bus driven in reset");
  property p_cap;
    (!reset_pin_n)[*6] |-> reset_config == $past(addr_data_bus, 4);
  endproperty
  a_cap: assert property (p_cap) else $error("config not captured");
  property p_keep;
    reset_pin_n[*6] |-> $stable(reset_config);
  endproperty
  a_keep: assert property (p_keep) else $error("config changed");
  property p_wr;
    psc_write && !core_reset && !pins_float && !fetch_start
      |=> psc_readback == $past(power_save_control) && psave_active == psc_readback[15];
  endproperty
  a_wr: assert property (p_wr) else $error("control write lost");
  property p_stay;
    psave_active && bus_state != 2'h2 && !psc_write && !core_reset |=> psave_active;
  endproperty
  a_stay: assert property (p_stay) else $error("early power-save exit");
  property p_exit;
    psave_active && irq && bus_state == 2'h2 |=> !psave_active;
  endproperty
  a_exit: assert property (p_exit) else $error("no power-save exit");
  property p_slow;
    psave_active && $past(psave_active) && cpu_clk_en && psc_readback[2:0] != 3'h0
      |=> !cpu_clk_en;
  endproperty
  a_slow: assert property (p_slow) else $error("core not slowed");
  property p_full;
    (psave_active && !pll_bypass && psc_readback[11:8] == 4'hB)[*2] |-> clkout_b_en;
  endproperty
  a_full: assert property (p_full) else $error("clock b not full rate");
endmodule : rcp_props
bind reset_clock_power_control rcp_props i_props (.clock, .resetn, .reset_pin_n,
  .addr_data_bus, .power_save_control, .psc_write, .irq, .bus_state, .reset_config,
  .psc_readback, .core_reset, .watchdog_reset, .pll_bypass, .cpu_clk_en, .clkout_b_en,
  .bus_drive_en, .pins_float, .fetch_start, .fetch_addr, .upper_select_n, .fetch_waits,
  .psave_active);

// ==== testbench/reset_clock_power_control_tb_top.sv ====
/*
  Self-checking bench for reset_clock_power_control.
  Assumes the strap board model and the checker are compiled first.
*/
`timescale 1ns/1ns
module reset_clock_power_control_tb_top import rcp_pkg::*;;
  logic        clock = 1'b0, resetn = 1'b0, reset_pin_n = 1'b0, psc_write = 1'b0, irq = 1'b0;
  logic        clock_halving_strap_n = 1'b1, emulation_strap_low_n = 1'b1;
  logic        emulation_strap_high_n = 1'b1;
  logic [1:0]  bus_state = 2'h0, fetch_waits;
  logic [15:0] cfg_value = 16'hA55A, power_save_control = 16'h0000, addr_data_bus;
  logic [15:0] reset_config, psc_readback;
  logic [19:0] fetch_addr;
  logic        core_reset, watchdog_reset, pll_reset, pll_bypass, cpu_clk_en, periph_clk_en;
  logic        clkout_a_en, clkout_b_en, bus_drive_en, pins_float, fetch_start;
  logic        upper_select_n, psave_active;
  int          err_count = 0, check_count = 0;
  always #5 clock = ~clock;
  strap_board i_board (.clock, .reset_pin_n, .cfg_value, .addr_data_bus);
  // Short init interval keeps the run brief
  reset_clock_power_control #(.INIT_CYC(2)) i_dut (.clock, .resetn, .power_on(1'b1),
    .reset_pin_n, .addr_data_bus, .clock_halving_strap_n, .emulation_strap_low_n,
    .emulation_strap_high_n, .power_save_control, .psc_write, .irq, .bus_state,
    .reset_config, .psc_readback, .core_reset, .watchdog_reset, .pll_reset, .pll_bypass,
    .cpu_clk_en, .periph_clk_en, .clkout_a_en, .clkout_b_en, .bus_drive_en, .pins_float,
    .fetch_start, .fetch_addr, .upper_select_n, .fetch_waits, .psave_active);
  task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic pin_reset();
    int i;
    @(posedge clock);
    reset_pin_n <= 1'b0;
    // Hold shortened from the board's power-up minimum to keep runs brief
    repeat (8) @(posedge clock);
    reset_pin_n <= 1'b1;
    for (i = 0; i < 40 && fetch_start !== 1'b1 && pins_float !== 1'b1; i++)
      @(negedge clock);
  endtask : pin_reset
  task automatic wr(input logic [15:0] w);
    @(posedge clock);
    power_save_control <= w;
    psc_write <= 1'b1;
    @(posedge clock);
    psc_write <= 1'b0;
    @(negedge clock);
    cmp(psc_readback, w);
  endtask : wr
  task automatic t_boot();
    pin_reset();
    cmp(fetch_start, 1'b1);
    cmp({fetch_addr, fetch_waits, upper_select_n}, {20'hFFFF0, 2'h3, 1'b0});
    @(negedge clock);
    cmp(reset_config, 16'hA55A);
    cmp({bus_drive_en, pins_float, pll_bypass}, 3'h4);
    cmp(psc_readback, 16'h0300);
    $display("t_boot done");
  endtask : t_boot
  task automatic t_psave();
    int n;
    n = 0;
    wr(16'h8B02);
    cmp(psave_active, 1'b1);
    repeat (12)
    begin
      @(negedge clock);
      n += cpu_clk_en + periph_clk_en;
    end
    cmp(n, 8);
    cmp(clkout_b_en, 1'b1);
    @(posedge clock);
    irq <= 1'b1;
    repeat (3) @(posedge clock);
    bus_state <= 2'h2;
    @(negedge clock);
    cmp(psave_active, 1'b1);
    @(posedge clock);
    bus_state <= 2'h0;
    irq <= 1'b0;
    @(negedge clock);
    cmp({psave_active, psc_readback}, {1'b0, 16'h0B02});
    wr(16'h0000);
    repeat (2) @(negedge clock);
    cmp({clkout_a_en, clkout_b_en}, 2'h0);
    $display("t_psave done");
  endtask : t_psave
  task automatic t_float();
    emulation_strap_low_n <= 1'b0;
    emulation_strap_high_n <= 1'b0;
    pin_reset();
    repeat (6) @(negedge clock);
    cmp({pins_float, bus_drive_en}, 2'h2);
    wr(16'h0300);
    emulation_strap_low_n <= 1'b1;
    emulation_strap_high_n <= 1'b1;
    pin_reset();
    cmp(fetch_start, 1'b1);
    $display("t_float done");
  endtask : t_float
  task automatic t_halve();
    @(posedge clock);
    resetn <= 1'b0;
    clock_halving_strap_n <= 1'b0;
    @(posedge clock);
    @(negedge clock);
    cmp(pll_reset, 1'b1);
    @(posedge clock);
    resetn <= 1'b1;
    pin_reset();
    repeat (2) @(negedge clock);
    cmp(pll_bypass, 1'b1);
    $display("t_halve done");
  endtask : t_halve
  initial
  begin
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    t_boot();
    t_psave();
    t_float();
    t_halve();
    give_verdict();
  end
  initial
  begin
    repeat (3000) @(posedge clock);
    err_count++;
    give_verdict();
  end
endmodule : reset_clock_power_control_tb_top
